// ==== hw/pief_pkg.sv ====
// Shared constants of the peripheral interrupt enable and flag block
package pief_pkg;

    // Number of peripheral sources held in each register
    localparam int SRC_N = 8;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_ENABLES = 8'h8C;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // Source bit positions, same in enables and flags
    localparam int BIT_PARALLEL_PORT = 7;
    localparam int BIT_CONVERTER_DONE = 6;
    localparam int BIT_SERIAL_RX = 5;
    localparam int BIT_SERIAL_TX = 4;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_CAPCMP_ONE = 2;
    localparam int BIT_TIMER_B_MATCH = 1;
    localparam int BIT_TIMER_A_OVERFLOW = 0;

    // Flags that software can only read
    localparam logic [7:0] FLAG_RO_MASK = 8'h30;

    // Core control bit positions
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_PERIPH_GROUP_ENABLE = 6;

    // Local interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_BIT_REQ_RAISED = 0;
    localparam int IRQ_BIT_SET_MASKED = 1;

    // Reset values
    localparam logic [7:0] RST_FLAGS = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_CORE_CTRL = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;

endpackage

// ==== hw/pief_flag_if.sv ====
`timescale 1ns/10ps
// Carries peripheral events and software writes into the flag bank
interface pief_flag_if;
    logic [7:0] event_set;   // One-cycle set pulses per source
    logic rx_full;           // Receive buffer full level
    logic tx_empty;          // Transmit buffer empty level
    logic wr_stb;            // Software write of the flag register
    logic [7:0] wr_data;     // Data of that write
    logic [7:0] flags;       // Current flag register
    logic [7:0] rise;        // Flags turning on this cycle

    // Flag storage side
    modport bank (
        input event_set, rx_full, tx_empty, wr_stb, wr_data,
        output flags, rise
    );
    // Controller side
    modport ctrl (
        output event_set, rx_full, tx_empty, wr_stb, wr_data,
        input flags, rise
    );
endinterface

// ==== hw/pief_flag_bank.sv ====
`timescale 1ns/10ps
module pief_flag_bank (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Controller side
    pief_flag_if.bank fi
);

    logic [7:0] flags_q;     // Flag register
    logic [7:0] flags_d;     // Its next value

    // Next flag value: software write, then hardware sets on top
    always_comb begin
        flags_d = flags_q;
        // Writable flags take the written value
        if (fi.wr_stb) begin
            flags_d = (fi.wr_data & ~pief_pkg::FLAG_RO_MASK) |
                      (flags_q & pief_pkg::FLAG_RO_MASK);
        end
        // Set wins over a clear in the same cycle
        flags_d = flags_d | (fi.event_set & ~pief_pkg::FLAG_RO_MASK);
        // Serial flags follow the buffer levels only
        flags_d[pief_pkg::BIT_SERIAL_RX] = fi.rx_full;
        flags_d[pief_pkg::BIT_SERIAL_TX] = fi.tx_empty;
    end

    // Flag storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_q <= pief_pkg::RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign fi.flags = flags_q;
    assign fi.rise = flags_d & ~flags_q;

    // An event on a writable flag always leaves that flag set next cycle
    a_event_sets_flag: assert property (@(posedge clk_sys)
        disable iff (rst)
        (|(fi.event_set & ~pief_pkg::FLAG_RO_MASK)) |=>
        ((flags_q & $past(fi.event_set) & ~pief_pkg::FLAG_RO_MASK) ==
         ($past(fi.event_set) & ~pief_pkg::FLAG_RO_MASK)))
        else $error("peripheral event did not set its flag");

    // Serial flags ignore software writes
    a_serial_flags_ro: assert property (@(posedge clk_sys)
        disable iff (rst)
        fi.wr_stb |=> (flags_q[5:4] == $past({fi.rx_full, fi.tx_empty})))
        else $error("serial flag changed by a write");

endmodule

// ==== hw/pief_irq_unit.sv ====
`timescale 1ns/10ps
module pief_irq_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Events from the block
    input wire logic [1:0] events,
    // Software access
    input wire logic wr_stat,
    input wire logic wr_mask,
    input wire logic [1:0] wr_data,
    // State
    output logic [1:0] stat,
    output logic [1:0] mask,
    output logic irq
);

    logic [1:0] stat_q;  // Sticky status
    logic [1:0] mask_q;  // Interrupt mask
    logic irq_q;         // Level interrupt

    // Status: write one clears, an event in the same cycle wins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_q <= pief_pkg::RST_IRQ;
        end else begin
            stat_q <= (stat_q & ~(wr_stat ? wr_data : 2'h0)) | events;
        end
    end

    // Mask register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_q <= pief_pkg::RST_IRQ;
        end else if (wr_mask) begin
            mask_q <= wr_data;
        end
    end

    // Interrupt follows unmasked status one cycle later
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    assign stat = stat_q;
    assign mask = mask_q;
    assign irq = irq_q;

    // The line tracks masked status with one cycle of lag
    a_irq_line_level: assert property (@(posedge clk_sys) disable iff (rst)
        ##1 irq_q == $past(|(stat_q & mask_q)))
        else $error("interrupt line does not follow masked status");

endmodule

// ==== hw/pief_top.sv ====
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
// How it works
// - Enable register at 8Ch, resets to zero
// - Enable bits ordered parallel port down timer overflow
// - Enable bit one passes, zero blocks source
// - Group enable clear blocks every peripheral request
// - Flag register at 0Ch; serial flags read-only
// - Events set flags regardless of any enable
module pief_top #(
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Peripheral side
    input wire logic [7:0] periph_event,
    input wire logic serial_rx_full,
    input wire logic serial_tx_empty,
    // Core side
    output logic periph_irq_req,
    output logic core_irq_req,
    // Local interrupt
    output logic irq
);

    // Elaboration check: the map needs eight address bits
    if (AW < 8) begin : g_aw_check
        $error("AW must be at least 8");
    end

    // Address match against a register offset
    function automatic logic hit(input logic [AW-1:0] adr,
                                 input logic [7:0] ofs);
        hit = (adr == AW'(ofs));
    endfunction

    // Bus state
    logic ack_q;             // Acknowledge register
    logic [31:0] dat_q;      // Read data register
    logic req_now;           // Request present and not yet acked
    logic wr_go;             // Write takes effect this edge
    logic [7:0] rd_mux;      // Read value of the addressed register

    // Register state
    logic [7:0] en_q;        // Enable register
    logic [7:0] ctrl_q;      // Core control: global and group enable

    // Request state
    logic pend;              // Some flag meets its enable
    logic preq_d;            // Next peripheral request
    logic preq_q;            // Peripheral request to the core
    logic creq_q;            // Request taken by the core

    // Local interrupt wiring
    logic [1:0] irq_events;  // Events into the status register
    logic [1:0] irq_stat;    // Sticky status
    logic [1:0] irq_mask;    // Mask
    logic irq_line;          // Level interrupt

    // Flag bank connection
    pief_flag_if fif ();

    // A request stands between strobe and acknowledge
    assign req_now = wb_cyc_i & wb_stb_i & ~ack_q;

    // Writes land at the edge that samples the acknowledge
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];

    // Acknowledge one cycle after the strobe, one cycle wide
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_now;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = 8'h00;
        // Flag register
        if (hit(wb_adr_i, pief_pkg::OFS_FLAGS)) begin
            rd_mux = fif.flags;
        end
        // Enable register
        if (hit(wb_adr_i, pief_pkg::OFS_ENABLES)) begin
            rd_mux = en_q;
        end
        // Core control register
        if (hit(wb_adr_i, pief_pkg::OFS_CORE_CTRL)) begin
            rd_mux = ctrl_q;
        end
        // Local interrupt status
        if (hit(wb_adr_i, pief_pkg::OFS_IRQ_STAT)) begin
            rd_mux = {6'h00, irq_stat};
        end
        // Local interrupt mask
        if (hit(wb_adr_i, pief_pkg::OFS_IRQ_MASK)) begin
            rd_mux = {6'h00, irq_mask};
        end
    end

    // Read data is captured with the acknowledge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dat_q <= 32'h0000_0000;
        end else if (req_now) begin
            dat_q <= {24'h00_0000, rd_mux};
        end
    end

    // Enable register: one bit per source, plain read and write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_q <= pief_pkg::RST_ENABLES;
        end else if (wr_go && hit(wb_adr_i, pief_pkg::OFS_ENABLES)) begin
            // Bit order: parallel port at 7 down to timer A at 0
            en_q <= wb_dat_i[7:0];
        end
    end

    // Core control register: only the two enable bits exist
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= pief_pkg::RST_CORE_CTRL;
        end else if (wr_go && hit(wb_adr_i, pief_pkg::OFS_CORE_CTRL)) begin
            ctrl_q <= {wb_dat_i[7:6], 6'h00};
        end
    end

    // Flag bank inputs
    assign fif.event_set = periph_event;
    assign fif.rx_full = serial_rx_full;
    assign fif.tx_empty = serial_tx_empty;
    assign fif.wr_stb = wr_go && hit(wb_adr_i, pief_pkg::OFS_FLAGS);
    assign fif.wr_data = wb_dat_i[7:0];

    // Flag storage
    pief_flag_bank u_flags (
        .clk_sys(clk_sys),
        .rst(rst),
        .fi(fif.bank)
    );

    // A source is pending when its flag and enable are both set
    assign pend = |(fif.flags & en_q);

    // The group enable must be set for any request
    assign preq_d = pend & ctrl_q[pief_pkg::BIT_PERIPH_GROUP_ENABLE];

    // Peripheral request and the core's global gate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            preq_q <= 1'b0;
            creq_q <= 1'b0;
        end else begin
            // Raised whenever a flag meets its enable and the group enable is set
            preq_q <= preq_d;
            // Taken only with the global enable too
            creq_q <= preq_d & ctrl_q[pief_pkg::BIT_GLOBAL_IRQ_ENABLE];
        end
    end

    // Local interrupt events
    always_comb begin
        irq_events = 2'h0;
        // Request to the core has just risen
        irq_events[pief_pkg::IRQ_BIT_REQ_RAISED] = preq_d & ~preq_q;
        // A flag turned on while its source is disabled
        irq_events[pief_pkg::IRQ_BIT_SET_MASKED] = |(fif.rise & ~en_q);
    end

    // Sticky status, mask and interrupt line
    pief_irq_unit u_irq (
        .clk_sys(clk_sys),
        .rst(rst),
        .events(irq_events),
        .wr_stat(wr_go && hit(wb_adr_i, pief_pkg::OFS_IRQ_STAT)),
        .wr_mask(wr_go && hit(wb_adr_i, pief_pkg::OFS_IRQ_MASK)),
        .wr_data(wb_dat_i[1:0]),
        .stat(irq_stat),
        .mask(irq_mask),
        .irq(irq_line)
    );

    // Outputs straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign periph_irq_req = preq_q;
    assign core_irq_req = creq_q;
    assign irq = irq_line;

    // Reset clears the enable register
    a_enable_reset_zero: assert property (@(posedge clk_sys)
        rst |=> (en_q == 8'h00))
        else $error("enable register not zero after reset");

    // A write at 8Ch lands in the enable register
    a_enable_write_lands: assert property (@(posedge clk_sys)
        disable iff (rst)
        (wr_go && hit(wb_adr_i, pief_pkg::OFS_ENABLES)) |=>
        (en_q == $past(wb_dat_i[7:0])))
        else $error("enable write not stored");

    // Transmit flag is gated by bit 4 of the enables
    a_tx_bit_gate: assert property (@(posedge clk_sys)
        disable iff (rst)
        ((fif.flags == 8'h10) && (en_q == 8'hEF)
         && ctrl_q[pief_pkg::BIT_PERIPH_GROUP_ENABLE]) |=> !preq_q)
        else $error("transmit flag passed with bit 4 clear");

    // A cleared enable blocks its source
    a_disabled_blocked: assert property (@(posedge clk_sys)
        disable iff (rst)
        ((fif.flags & en_q) == 8'h00) |=> !preq_q)
        else $error("request without a flag and enable pair");

    // Group enable clear blocks both requests
    a_group_blocks: assert property (@(posedge clk_sys)
        disable iff (rst)
        !ctrl_q[pief_pkg::BIT_PERIPH_GROUP_ENABLE] |=> (!preq_q && !creq_q))
        else $error("request with group enable clear");

    // Reset clears the flag register
    a_flag_reset_zero: assert property (@(posedge clk_sys)
        rst ##1 !rst |-> ((fif.flags & ~pief_pkg::FLAG_RO_MASK) == 8'h00))
        else $error("flag register not zero after reset");

    // A writable flag written zero clears unless an event arrives
    a_flag_write_clears: assert property (@(posedge clk_sys)
        disable iff (rst)
        (fif.wr_stb && !wb_dat_i[0] && !periph_event[0]) |=> !fif.flags[0])
        else $error("flag write of zero did not clear");

    // An event sets its flag even with everything disabled
    a_event_ignores_enables: assert property (@(posedge clk_sys)
        disable iff (rst)
        (periph_event[pief_pkg::BIT_CAPCMP_ONE] && ctrl_q == 8'h00
         && en_q == 8'h00) |=> fif.flags[pief_pkg::BIT_CAPCMP_ONE])
        else $error("event lost while enables clear");

    // Matching flag and enable with group enable raises request
    a_request_raised: assert property (@(posedge clk_sys)
        disable iff (rst)
        (pend && ctrl_q[pief_pkg::BIT_PERIPH_GROUP_ENABLE]) |=> preq_q)
        else $error("request not raised for a pending source");

    // The core request needs the global enable on top
    a_core_needs_global: assert property (@(posedge clk_sys)
        disable iff (rst)
        ##1 creq_q == ($past(preq_d)
            && $past(ctrl_q[pief_pkg::BIT_GLOBAL_IRQ_ENABLE])))
        else $error("core request does not match its gates");

    // Acknowledge lasts exactly one cycle per request
    a_ack_one_cycle: assert property (@(posedge clk_sys)
        disable iff (rst)
        ack_q |=> !ack_q)
        else $error("acknowledge longer than one cycle");

    // Every request taken is answered in the next cycle
    a_ack_follows_req: assert property (@(posedge clk_sys)
        disable iff (rst)
        req_now |=> ack_q)
        else $error("request not acknowledged in one cycle");

    // No acknowledge without a request taken just before
    a_ack_needs_req: assert property (@(posedge clk_sys)
        disable iff (rst)
        ack_q |-> $past(req_now))
        else $error("acknowledge without a request");

    // Read data shows the register sampled with the request
    a_read_data_held: assert property (@(posedge clk_sys)
        disable iff (rst)
        req_now |=> (dat_q == {24'h00_0000, $past(rd_mux)}))
        else $error("read data does not match the register");

    // Enables only change through an accepted write
    a_enable_write_only: assert property (@(posedge clk_sys)
        disable iff (rst)
        !(wr_go && hit(wb_adr_i, pief_pkg::OFS_ENABLES)) |=> $stable(en_q))
        else $error("enable register changed without a write");

    // Unused core control bits always hold zero
    a_ctrl_spare_zero: assert property (@(posedge clk_sys)
        disable iff (rst)
        ctrl_q[5:0] == 6'h00)
        else $error("spare core control bits set");

    // Global enable clear keeps the core request low
    a_global_blocks: assert property (@(posedge clk_sys)
        disable iff (rst)
        !ctrl_q[pief_pkg::BIT_GLOBAL_IRQ_ENABLE] |=> !creq_q)
        else $error("core request with global enable clear");

    // The core request never stands without the peripheral one
    a_core_under_periph: assert property (@(posedge clk_sys)
        disable iff (rst)
        creq_q |-> preq_q)
        else $error("core request without peripheral request");

    // Receive flag tracks its buffer level one cycle later
    a_rx_flag_level: assert property (@(posedge clk_sys)
        disable iff (rst)
        ##1 fif.flags[pief_pkg::BIT_SERIAL_RX] == $past(serial_rx_full))
        else $error("receive flag does not follow its level");

    // Transmit flag tracks its buffer level one cycle later
    a_tx_flag_level: assert property (@(posedge clk_sys)
        disable iff (rst)
        ##1 fif.flags[pief_pkg::BIT_SERIAL_TX] == $past(serial_tx_empty))
        else $error("transmit flag does not follow its level");

    // Writable flags hold without a write or an event
    a_flags_hold: assert property (@(posedge clk_sys)
        disable iff (rst)
        (!fif.wr_stb && periph_event == 8'h00) |=>
        ((fif.flags & ~pief_pkg::FLAG_RO_MASK) ==
         ($past(fif.flags) & ~pief_pkg::FLAG_RO_MASK)))
        else $error("writable flag changed by itself");

    // A flag rising on a disabled source is recorded
    a_masked_rise_seen: assert property (@(posedge clk_sys)
        disable iff (rst)
        irq_events[pief_pkg::IRQ_BIT_SET_MASKED] |=>
        irq_stat[pief_pkg::IRQ_BIT_SET_MASKED])
        else $error("masked flag rise not recorded");

    // A rise of the peripheral request is recorded
    a_req_rise_seen: assert property (@(posedge clk_sys)
        disable iff (rst)
        irq_events[pief_pkg::IRQ_BIT_REQ_RAISED] |=>
        irq_stat[pief_pkg::IRQ_BIT_REQ_RAISED])
        else $error("request rise not recorded");

endmodule

// ==== dv/pief_periph_model.sv ====
`timescale 1ns/10ps
// Stands in for the peripheral modules that feed the flag bank
module pief_periph_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Requests from the bench
    input wire logic [7:0] ev_req,
    input wire logic rx_lvl,
    input wire logic tx_lvl,
    // Peripheral lines to the block
    output logic [7:0] periph_event,
    output logic serial_rx_full,
    output logic serial_tx_empty
);
    // One-cycle condition pulses, issued whatever the enables hold
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            periph_event <= 8'h00;
        end else begin
            periph_event <= ev_req;
        end
    end

    // Serial buffer levels are plain levels from the serial unit
    assign serial_rx_full = rx_lvl;
    assign serial_tx_empty = tx_lvl;
endmodule

// ==== dv/tb_pief_top.sv ====
`timescale 1ns/10ps
// Self-checking bench of the peripheral interrupt enable and flag block
module tb_pief_top;
    // Clock, reset and bus master signals
    logic clk_sys, rst, cyc, stb, we, wb_ack_o;
    logic [7:0] adr, r, ev_req, periph_event;
    logic [3:0] sel;
    logic [31:0] dat, wb_dat_o, q;
    // Peripheral and core side
    logic rx, tx, serial_rx_full, serial_tx_empty;
    logic periph_irq_req, core_irq_req, irq;
    int num_errors, n_checks;

    pief_top #(.AW(8)) i_pief_top (
        .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .periph_event(periph_event), .serial_rx_full(serial_rx_full),
        .serial_tx_empty(serial_tx_empty),
        .periph_irq_req(periph_irq_req), .core_irq_req(core_irq_req),
        .irq(irq)
    );

    pief_periph_model i_pief_periph_model (
        .clk_sys(clk_sys), .rst(rst), .ev_req(ev_req), .rx_lvl(rx),
        .tx_lvl(tx), .periph_event(periph_event),
        .serial_rx_full(serial_rx_full), .serial_tx_empty(serial_tx_empty)
    );

    // 40 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task close_out;
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare a register word
    task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Compare a one-bit output
    task chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle, held until ack is seen
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
            input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        n = 0;
        // Ack is looked at as the slave's edge samples it
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            $display("BAD bus ack expected 1 seen timeout");
            close_out;
        end
        // Read data taken and request released at the ack edge
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Register write and read shorthands
    task wr(input logic [7:0] a, input logic [7:0] d);
        wb(a, 1'b1, {24'h000000, d}, 4'hF);
    endtask

    task rd(input logic [7:0] a);
        wb(a, 1'b0, 32'h00000000, 4'hF);
    endtask

    // Pulse chosen peripheral conditions for one cycle
    task fire(input logic [7:0] m);
        @(posedge clk_sys);
        ev_req <= m;
        @(posedge clk_sys);
        ev_req <= 8'h00;
    endtask

    // Let n edges pass, then sit where outputs are settled
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Flag readback after a write: serial bits follow their levels
    function automatic logic [31:0] exp_flags(input logic [7:0] w,
                                              input logic a, input logic b);
        return {24'h000000,
                (w & ~pief_pkg::FLAG_RO_MASK) | {2'h0, a, b, 4'h0}};
    endfunction

    // Main sequence
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h00000000;
        ev_req = 8'h00;
        rx = 1'b0;
        tx = 1'b0;
        num_errors = 0;
        n_checks = 0;
        void'($urandom(12289));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and an unmapped place
        rd(pief_pkg::OFS_ENABLES);
        chk_reg("enables reset", {24'h0, pief_pkg::RST_ENABLES}, q);
        rd(pief_pkg::OFS_FLAGS);
        chk_reg("flags reset", {24'h0, pief_pkg::RST_FLAGS}, q);
        rd(8'h40);
        chk_reg("unmapped read", 32'h00000000, q);
        // Enable register read back, then a write with byte lane off
        for (int i = 0; i < 6; i++) begin
            r = 8'($urandom);
            wr(pief_pkg::OFS_ENABLES, r);
            rd(pief_pkg::OFS_ENABLES);
            chk_reg("enables rw", {24'h000000, r}, q);
        end
        wb(pief_pkg::OFS_ENABLES, 1'b1, 32'h000000FF, 4'h0);
        rd(pief_pkg::OFS_ENABLES);
        chk_reg("enables lane off", {24'h000000, r}, q);
        wr(pief_pkg::OFS_ENABLES, 8'h00);
        // Flag writes against random serial levels
        for (int i = 0; i < 6; i++) begin
            r = 8'($urandom);
            @(posedge clk_sys);
            rx <= 1'($urandom);
            tx <= 1'($urandom);
            wr(pief_pkg::OFS_FLAGS, r);
            rd(pief_pkg::OFS_FLAGS);
            chk_reg("flags rw", exp_flags(r, rx, tx), q);
        end
        @(posedge clk_sys);
        rx <= 1'b0;
        tx <= 1'b0;
        wr(pief_pkg::OFS_FLAGS, 8'h00);
        // Core control keeps only its two enable bits
        wr(pief_pkg::OFS_CORE_CTRL, 8'hFF);
        rd(pief_pkg::OFS_CORE_CTRL);
        chk_reg("core ctrl", 32'h000000C0, q);
        // Events with every enable clear; local status and mask
        wr(pief_pkg::OFS_CORE_CTRL, 8'h00);
        wr(pief_pkg::OFS_IRQ_STAT, 8'h03);
        wr(pief_pkg::OFS_IRQ_MASK, 8'h02);
        r = 8'($urandom) | 8'h01;
        fire(r);
        tick(3);
        chk_bit("core req blocked", 1'b0, core_irq_req);
        chk_bit("irq on masked rise", 1'b1, irq);
        rd(pief_pkg::OFS_FLAGS);
        chk_reg("flags on events", exp_flags(r, 1'b0, 1'b0), q);
        rd(pief_pkg::OFS_IRQ_STAT);
        chk_reg("status masked rise", 32'h00000002, q);
        wr(pief_pkg::OFS_IRQ_MASK, 8'h01);
        tick(2);
        chk_bit("irq masked off", 1'b0, irq);
        wr(pief_pkg::OFS_IRQ_STAT, 8'h03);
        wr(pief_pkg::OFS_IRQ_MASK, 8'h03);
        // Each source through its enable, the group and global gates
        for (int b = 0; b < 8; b++) begin
            wr(pief_pkg::OFS_ENABLES, 8'h00);
            wr(pief_pkg::OFS_FLAGS, 8'h00);
            wr(pief_pkg::OFS_CORE_CTRL, 8'hC0);
            wr(pief_pkg::OFS_ENABLES, 8'h01 << b);
            @(posedge clk_sys);
            rx <= (b == pief_pkg::BIT_SERIAL_RX);
            tx <= (b == pief_pkg::BIT_SERIAL_TX);
            fire(8'h01 << b);
            tick(3);
            chk_bit("periph req", 1'b1, periph_irq_req);
            chk_bit("core req", 1'b1, core_irq_req);
            rd(pief_pkg::OFS_FLAGS);
            chk_reg("flag position", {24'h0, 8'h01 << b}, q);
            wr(pief_pkg::OFS_CORE_CTRL, 8'h40);
            tick(2);
            chk_bit("periph req no global", 1'b1, periph_irq_req);
            chk_bit("core req no global", 1'b0, core_irq_req);
            wr(pief_pkg::OFS_CORE_CTRL, 8'h80);
            tick(2);
            chk_bit("periph req no group", 1'b0, periph_irq_req);
            chk_bit("core req no group", 1'b0, core_irq_req);
            wr(pief_pkg::OFS_CORE_CTRL, 8'hC0);
            wr(pief_pkg::OFS_ENABLES, ~(8'h01 << b));
            tick(2);
            chk_bit("periph req own off", 1'b0, periph_irq_req);
            @(posedge clk_sys);
            rx <= 1'b0;
            tx <= 1'b0;
        end
        // Request rises were recorded; clear them by writing one
        tick(2);
        chk_bit("irq on request rise", 1'b1, irq);
        rd(pief_pkg::OFS_IRQ_STAT);
        chk_reg("status request rose", 32'h00000001, q);
        wr(pief_pkg::OFS_IRQ_STAT, 8'h01);
        tick(2);
        chk_bit("irq cleared", 1'b0, irq);
        close_out;
    end
endmodule
